// ===== serial_vid_params.svh
// timing, level and framing constants of the serial vid plane control
`ifndef SERIAL_VID_PARAMS_SVH
`define SERIAL_VID_PARAMS_SVH

// ------------------
// clock and slew
// ------------------
`define SVID_CLK_MHZ 100
`define SVID_SLEW_UV_PER_US 3250
`define SVID_LSB_UV 12500
// one reference lsb per step; a rate, so the count rounds down
`define SVID_STEP_CYCLES ((`SVID_LSB_UV * `SVID_CLK_MHZ) / `SVID_SLEW_UV_PER_US)

// ------------------
// levels, in units of one 12.5 mv lsb above zero
// ------------------
`define SVID_TOP_LEVEL 7'h7c
`define SVID_OFF_CODE 7'h7c
`define SVID_ZERO_LEVEL 7'h00
`define SVID_FIX_LVL_00 7'h70
`define SVID_FIX_LVL_01 7'h60
`define SVID_FIX_LVL_10 7'h50
`define SVID_FIX_LVL_11 7'h40
`define SVID_BOOT_LVL_00 7'h58
`define SVID_BOOT_LVL_01 7'h50
`define SVID_BOOT_LVL_10 7'h48
`define SVID_BOOT_LVL_11 7'h40

// ------------------
// frame layout: address byte is prefix, core, nb, spare, write bit
// ------------------
`define SVID_ADDR_PREFIX 4'hc
`define SVID_CORE_SEL_BIT 3
`define SVID_NB_SEL_BIT 2
`define SVID_PSI_BIT 7
`define SVID_BITS_PER_BYTE 4'h8
`define SVID_ACK_SLOT 4'h9

`endif

// ===== svid_pkg.sv
// types shared by the serial vid plane control
package svid_pkg;

   typedef logic [6:0] level_t;

   typedef struct packed {
      logic core_sel;
      logic nb_sel;
      logic psi_n;
      logic [6:0] code;
   } svi_cmd_s;

   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_SOFT = 2'b01,
      ST_RUN = 2'b11,
      ST_DOWN = 2'b10
   } plane_state_e;

endpackage : svid_pkg

// ===== svi_frame_rx.sv
// receiver of set-vid frames on the two-wire serial voltage id bus
`timescale 1ns/10ps
`default_nettype none
`include "serial_vid_params.svh"

module svi_frame_rx
   import svid_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic clk_pin_i,
   input wire logic data_pin_i,
   output logic data_o,
   output logic data_oe_o,
   output logic clk_level_o,
   output logic data_level_o,
   output logic cmd_valid_o,
   output svi_cmd_s cmd_o
);

   // ------------------
   // pin synchronisers
   // ------------------
   logic clk_s1_q, clk_s2_q, clk_s3_q;
   logic dat_s1_q, dat_s2_q, dat_s3_q;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         clk_s1_q <= 1'b1;
         clk_s2_q <= 1'b1;
         clk_s3_q <= 1'b1;
         dat_s1_q <= 1'b1;
         dat_s2_q <= 1'b1;
         dat_s3_q <= 1'b1;
      end else begin
         clk_s1_q <= clk_pin_i;
         clk_s2_q <= clk_s1_q;
         clk_s3_q <= clk_s2_q;
         dat_s1_q <= data_pin_i;
         dat_s2_q <= dat_s1_q;
         dat_s3_q <= dat_s2_q;
      end
   end

   assign clk_level_o = clk_s2_q;
   assign data_level_o = dat_s2_q;

   logic clk_rise, clk_fall, start_seen, stop_seen;
   assign clk_rise = clk_s2_q & ~clk_s3_q;
   assign clk_fall = ~clk_s2_q & clk_s3_q;
   assign start_seen = clk_s2_q & clk_s3_q & dat_s3_q & ~dat_s2_q;
   assign stop_seen = clk_s2_q & clk_s3_q & ~dat_s3_q & dat_s2_q;

   // ------------------
   // frame sequencing
   // ------------------
   logic busy_q, byte_q, ack_q, got_data_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] shift_q;
   logic core_sel_q, nb_sel_q;
   logic [7:0] data_byte_q;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         busy_q <= 1'b0;
         byte_q <= 1'b0;
         ack_q <= 1'b0;
         got_data_q <= 1'b0;
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         core_sel_q <= 1'b0;
         nb_sel_q <= 1'b0;
         data_byte_q <= 8'h00;
      end else if (start_seen) begin
         busy_q <= 1'b1;
         byte_q <= 1'b0;
         ack_q <= 1'b0;
         got_data_q <= 1'b0;
         bit_cnt_q <= 4'h0;
      end else if (stop_seen) begin
         busy_q <= 1'b0;
         ack_q <= 1'b0;
         got_data_q <= 1'b0;
      end else if (busy_q && clk_rise) begin
         if (bit_cnt_q < `SVID_BITS_PER_BYTE) begin
            shift_q <= {shift_q[6:0], dat_s2_q};
         end
         bit_cnt_q <= bit_cnt_q + 4'h1;
      end else if (busy_q && clk_fall) begin
         if (bit_cnt_q == `SVID_BITS_PER_BYTE) begin
            if (!byte_q) begin
               // a frame for another slave or a read is left alone to its stop
               if (shift_q[7:4] == `SVID_ADDR_PREFIX && !shift_q[0]) begin
                  ack_q <= 1'b1;
                  core_sel_q <= shift_q[`SVID_CORE_SEL_BIT];
                  nb_sel_q <= shift_q[`SVID_NB_SEL_BIT];
               end else begin
                  busy_q <= 1'b0;
               end
            end else begin
               ack_q <= 1'b1;
               data_byte_q <= shift_q;
               got_data_q <= 1'b1;
            end
         end else if (bit_cnt_q == `SVID_ACK_SLOT) begin
            ack_q <= 1'b0;
            bit_cnt_q <= 4'h0;
            // extra bytes after the data byte are not acknowledged
            busy_q <= ~byte_q;
            byte_q <= 1'b1;
         end
      end
   end

   // ------------------
   // command hand-off at the stop condition
   // ------------------
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cmd_valid_o <= 1'b0;
         cmd_o <= '0;
      end else begin
         cmd_valid_o <= stop_seen & got_data_q;
         if (stop_seen && got_data_q) begin
            cmd_o.core_sel <= core_sel_q;
            cmd_o.nb_sel <= nb_sel_q;
            cmd_o.psi_n <= data_byte_q[`SVID_PSI_BIT];
            cmd_o.code <= data_byte_q[6:0];
         end
      end
   end

   // open drain: only ever pulls the data line low
   assign data_o = 1'b0;
   assign data_oe_o = ack_q;

endmodule : svi_frame_rx

`default_nettype wire

// ===== serial_vid_plane_control.sv
// dual-plane reference control: fixed mode, serial set-vid, power good, phase shedding
// What this block does
// - fixed mode decodes clock/data as target
// - fixed-mode inputs may change; targets follow
// - soft-start steps references up to target
// - power good after soft-start and regulation
// - enable loss ramps both planes to zero
// - set-vid decodes planes and code, steps
// - code zero 1.55 v, minus 12.5 mv, off codes
// - core off keeps power good; nb stays
// - power ok loss returns to boot vid
// - power ok return holds until next command
// - power good loss steps planes to zero
// - data bit 7 low asks power savings
// - shed channel 4, then 3, then 2
// - shed phase tristates at its next pwm high
// - restore phases from 2 at pwm high
// - vid change in savings: exit, step, re-enter
// - fixed codes give 1.4, 1.2, 1.0, 0.8 v
// - boot vid latched at enable rising edge
// - references slew at fixed rate to target
`timescale 1ns/10ps
`default_nettype none
`include "serial_vid_params.svh"

module serial_vid_plane_control
   import svid_pkg::*;
#(
   parameter int STEP_CYCLES = `SVID_STEP_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic enable_i,
   input wire logic fixed_vid_enable_i,
   input wire logic serial_vid_clock_i,
   input wire logic serial_vid_data_i,
   output logic serial_vid_data_o,
   output logic serial_vid_data_oe_o,
   input wire logic platform_power_ok_i,
   input wire logic planes_in_regulation_i,
   input wire logic [3:0] phase_fitted_i,
   input wire logic [3:0] phase_pwm_i,
   output level_t core_plane_ref_o,
   output level_t northbridge_plane_ref_o,
   output logic core_plane_off_o,
   output logic planes_power_good_o,
   output logic [3:0] phase_tristate_o,
   output logic power_save_active_o,
   output logic fixed_voltage_mode_o
);

   // ------------------
   // elaboration checks
   // ------------------
   if (STEP_CYCLES < 1 || STEP_CYCLES > 65535) begin : g_bad_step
      $error("STEP_CYCLES must lie in 1..65535");
   end

   // ------------------
   // decoding functions
   // ------------------
   function automatic level_t fixed_level(input logic c, input logic d);
      case ({c, d})
         2'b00: fixed_level = `SVID_FIX_LVL_00;
         2'b01: fixed_level = `SVID_FIX_LVL_01;
         2'b10: fixed_level = `SVID_FIX_LVL_10;
         default: fixed_level = `SVID_FIX_LVL_11;
      endcase
   endfunction : fixed_level

   function automatic level_t boot_level(input logic c, input logic d);
      case ({c, d})
         2'b00: boot_level = `SVID_BOOT_LVL_00;
         2'b01: boot_level = `SVID_BOOT_LVL_01;
         2'b10: boot_level = `SVID_BOOT_LVL_10;
         default: boot_level = `SVID_BOOT_LVL_11;
      endcase
   endfunction : boot_level

   // linear map with the top codes meaning plane off
   function automatic level_t code_level(input logic [6:0] code);
      if (code >= `SVID_OFF_CODE) begin
         code_level = `SVID_ZERO_LEVEL;
      end else begin
         code_level = `SVID_TOP_LEVEL - code;
      end
   endfunction : code_level

   function automatic level_t step_toward(input level_t cur, input level_t tgt);
      if (cur < tgt) begin
         step_toward = cur + 7'h01;
      end else if (cur > tgt) begin
         step_toward = cur - 7'h01;
      end else begin
         step_toward = cur;
      end
   endfunction : step_toward

   // ------------------
   // input synchronisers
   // ------------------
   logic [3:0] lvl_s1_q, lvl_s2_q;
   logic [3:0] fit_s1_q, fit_s2_q;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lvl_s1_q <= 4'h0;
         lvl_s2_q <= 4'h0;
         fit_s1_q <= 4'h1;
         fit_s2_q <= 4'h1;
      end else begin
         lvl_s1_q <= {enable_i, fixed_vid_enable_i, platform_power_ok_i, planes_in_regulation_i};
         lvl_s2_q <= lvl_s1_q;
         fit_s1_q <= phase_fitted_i;
         fit_s2_q <= fit_s1_q;
      end
   end

   logic en_s, fix_s, pok_s, reg_s;
   logic [3:0] fitted;
   assign en_s = lvl_s2_q[3];
   assign fix_s = lvl_s2_q[2];
   assign pok_s = lvl_s2_q[1];
   assign reg_s = lvl_s2_q[0];
   // channel 1 always switches
   assign fitted = fit_s2_q | 4'h1;

   // ------------------
   // serial receiver
   // ------------------
   logic svc_lvl, svd_lvl, cmd_valid;
   svi_cmd_s cmd;

   svi_frame_rx i_svi_frame_rx (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .clk_pin_i(serial_vid_clock_i),
      .data_pin_i(serial_vid_data_i),
      .data_o(serial_vid_data_o),
      .data_oe_o(serial_vid_data_oe_o),
      .clk_level_o(svc_lvl),
      .data_level_o(svd_lvl),
      .cmd_valid_o(cmd_valid),
      .cmd_o(cmd)
   );

   // ------------------
   // plane sequencing state
   // ------------------
   plane_state_e state_q, state_d;
   level_t core_ref_q, nb_ref_q, core_tgt_q, nb_tgt_q, boot_lvl_q;
   logic pok_prev_q;
   logic pok_fall, at_target, at_zero, cmd_ok, lvl_change;

   assign pok_fall = pok_prev_q & ~pok_s;
   assign at_target = (core_ref_q == core_tgt_q) && (nb_ref_q == nb_tgt_q);
   assign at_zero = (core_ref_q == `SVID_ZERO_LEVEL) && (nb_ref_q == `SVID_ZERO_LEVEL);
   // commands count only once power ok stands after power good
   assign cmd_ok = cmd_valid && (state_q == ST_RUN) && pok_s && !fix_s && !pok_fall;
   assign lvl_change = (cmd.core_sel && code_level(cmd.code) != core_tgt_q) ||
                       (cmd.nb_sel && code_level(cmd.code) != nb_tgt_q);

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_OFF: begin
            if (en_s) begin
               state_d = ST_SOFT;
            end
         end
         ST_SOFT: begin
            if (!en_s) begin
               state_d = ST_DOWN;
            end else if (at_target && reg_s) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!en_s) begin
               state_d = ST_DOWN;
            end else if (!reg_s) begin
               state_d = ST_DOWN;
            end
         end
         ST_DOWN: begin
            // a regulation fault stays latched until enable is dropped
            if (at_zero && !en_s) begin
               state_d = ST_OFF;
            end
         end
         default: begin
            state_d = ST_DOWN;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= ST_OFF;
         planes_power_good_o <= 1'b0;
         pok_prev_q <= 1'b0;
      end else begin
         state_q <= state_d;
         // an off core plane still reads as in regulation, so good holds
         planes_power_good_o <= (state_d == ST_RUN);
         pok_prev_q <= pok_s;
      end
   end

   // ------------------
   // boot vid holding register
   // ------------------
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         boot_lvl_q <= `SVID_ZERO_LEVEL;
      end else if (state_q == ST_OFF && en_s) begin
         boot_lvl_q <= boot_level(svc_lvl, svd_lvl);
      end
   end

   // ------------------
   // plane targets
   // ------------------
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         core_tgt_q <= `SVID_ZERO_LEVEL;
         nb_tgt_q <= `SVID_ZERO_LEVEL;
      end else begin
         case (state_q)
            ST_OFF: begin
               if (en_s && fix_s) begin
                  core_tgt_q <= fixed_level(svc_lvl, svd_lvl);
                  nb_tgt_q <= fixed_level(svc_lvl, svd_lvl);
               end else if (en_s) begin
                  core_tgt_q <= boot_level(svc_lvl, svd_lvl);
                  nb_tgt_q <= boot_level(svc_lvl, svd_lvl);
               end
            end
            ST_SOFT, ST_RUN: begin
               if (!en_s || (state_q == ST_RUN && !reg_s)) begin
                  core_tgt_q <= `SVID_ZERO_LEVEL;
                  nb_tgt_q <= `SVID_ZERO_LEVEL;
               end else if (fix_s) begin
                  core_tgt_q <= fixed_level(svc_lvl, svd_lvl);
                  nb_tgt_q <= fixed_level(svc_lvl, svd_lvl);
               end else if (pok_fall) begin
                  // the serial pins are not looked at again here
                  core_tgt_q <= boot_lvl_q;
                  nb_tgt_q <= boot_lvl_q;
               end else if (cmd_ok) begin
                  if (cmd.core_sel) begin
                     core_tgt_q <= code_level(cmd.code);
                  end
                  if (cmd.nb_sel) begin
                     nb_tgt_q <= code_level(cmd.code);
                  end
               end
               // otherwise targets hold, also across power ok returning
            end
            default: begin
               core_tgt_q <= `SVID_ZERO_LEVEL;
               nb_tgt_q <= `SVID_ZERO_LEVEL;
            end
         endcase
      end
   end

   // ------------------
   // reference slew
   // ------------------
   localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);
   logic [15:0] step_cnt_q;
   logic step_tick, slew_hold;
   logic save_req_q, resave_q;
   logic [3:0] tri_q;

   assign step_tick = (step_cnt_q == STEP_LAST);
   // while leaving savings for a vid change, the step waits for all phases
   assign slew_hold = resave_q && (tri_q != 4'h0);

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         step_cnt_q <= 16'h0000;
      end else if (step_tick || at_target) begin
         step_cnt_q <= 16'h0000;
      end else begin
         step_cnt_q <= step_cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         core_ref_q <= `SVID_ZERO_LEVEL;
         nb_ref_q <= `SVID_ZERO_LEVEL;
      end else if (step_tick && !slew_hold) begin
         core_ref_q <= step_toward(core_ref_q, core_tgt_q);
         nb_ref_q <= step_toward(nb_ref_q, nb_tgt_q);
      end
   end

   assign core_plane_ref_o = core_ref_q;
   assign northbridge_plane_ref_o = nb_ref_q;
   assign core_plane_off_o = (core_tgt_q == `SVID_ZERO_LEVEL) && (state_q == ST_RUN);
   assign fixed_voltage_mode_o = fix_s;

   // ------------------
   // power savings request
   // ------------------
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         save_req_q <= 1'b0;
         resave_q <= 1'b0;
      end else if (state_q != ST_RUN || fix_s) begin
         save_req_q <= 1'b0;
         resave_q <= 1'b0;
      end else if (cmd_ok && cmd.psi_n) begin
         save_req_q <= 1'b0;
         resave_q <= 1'b0;
      end else if (cmd_ok && save_req_q && lvl_change) begin
         save_req_q <= 1'b0;
         resave_q <= 1'b1;
      end else if (cmd_ok && !resave_q) begin
         save_req_q <= 1'b1;
      end else if (resave_q && tri_q == 4'h0 && at_target) begin
         save_req_q <= 1'b1;
         resave_q <= 1'b0;
      end
   end

   // ------------------
   // phase shedding and restoring
   // ------------------
   logic [3:0] pwm_prev_q;
   logic [3:0] pwm_rise, shed_pick, wake_pick;

   assign pwm_rise = phase_pwm_i & ~pwm_prev_q;

   // one channel moves at a time: highest fitted to shed, lowest to wake
   always_comb begin
      shed_pick = 4'h0;
      wake_pick = 4'h0;
      for (int i = 1; i < 4; i++) begin
         if (fitted[i] && !tri_q[i]) begin
            shed_pick = 4'h0;
            shed_pick[i] = 1'b1;
         end
      end
      for (int i = 3; i >= 1; i--) begin
         if (tri_q[i]) begin
            wake_pick = 4'h0;
            wake_pick[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pwm_prev_q <= 4'h0;
         tri_q <= 4'h0;
      end else begin
         pwm_prev_q <= phase_pwm_i;
         if (save_req_q) begin
            tri_q <= tri_q | (shed_pick & pwm_rise);
         end else begin
            tri_q <= tri_q & ~(wake_pick & pwm_rise);
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         phase_tristate_o <= 4'he;
         power_save_active_o <= 1'b0;
      end else begin
         // unfitted channels never switch
         phase_tristate_o <= tri_q | ~fitted;
         power_save_active_o <= save_req_q && ((tri_q | ~fitted) == 4'he);
      end
   end

endmodule : serial_vid_plane_control

`default_nettype wire

// ===== serial_vid_plane_control_assertions.sv
// checker for the serial vid plane control top ports
`timescale 1ns/10ps
`default_nettype none
module serial_vid_plane_control_assertions
   import svid_pkg::*;
#(
   parameter int STEP_CYCLES = 4
) (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic enable_i,
   input wire logic planes_in_regulation_i,
   input wire logic [3:0] phase_pwm_i,
   input wire level_t core_plane_ref_o,
   input wire logic core_plane_off_o,
   input wire logic planes_power_good_o,
   input wire logic [3:0] phase_tristate_o,
   input wire logic power_save_active_o
);
   // ------------------
   // plane and phase properties
   // ------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   // cycles since the core reference last moved; saturates instead of wrapping
   logic [15:0] gap_q;
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) gap_q <= 16'h0000;
      else if ($changed(core_plane_ref_o)) gap_q <= 16'h0000;
      else if (gap_q != 16'hffff) gap_q <= gap_q + 16'h0001;
   end
   property p_step;
      $changed(core_plane_ref_o) |->
         7'(core_plane_ref_o - $past(core_plane_ref_o)) inside {7'h01, 7'h7f};
   endproperty
   a_step: assert property (p_step) else $error("reference jumped");
   property p_slew; $changed(core_plane_ref_o) |-> gap_q >= STEP_CYCLES - 1; endproperty
   a_slew: assert property (p_slew) else $error("reference stepped too soon");
   property p_en; !enable_i [*5] |-> !planes_power_good_o; endproperty
   a_en: assert property (p_en) else $error("power good without enable");
   property p_reg; !planes_in_regulation_i [*5] |-> !planes_power_good_o; endproperty
   a_reg: assert property (p_reg) else $error("power good out of regulation");
   property p_pg; $rose(planes_power_good_o) |-> $stable(core_plane_ref_o); endproperty
   a_pg: assert property (p_pg) else $error("power good during ramp");
   property p_off; core_plane_off_o |-> planes_power_good_o; endproperty
   a_off: assert property (p_off) else $error("core off dropped power good");
   // only in run: start-up and shutdown may set all phases at once
   property p_shed;
      $rose(phase_tristate_o[3]) && planes_power_good_o && $past(planes_power_good_o)
         |-> $past(phase_pwm_i[3]);
   endproperty
   a_shed: assert property (p_shed) else $error("channel 4 shed off its pwm");
   property p_order; $rose(phase_tristate_o[2]) |-> phase_tristate_o[3] && !phase_tristate_o[0];
   endproperty
   a_order: assert property (p_order) else $error("shed order wrong");
   property p_wake;
      $fell(phase_tristate_o[1]) && planes_power_good_o && $past(planes_power_good_o)
         |-> $past(phase_pwm_i[1]);
   endproperty
   a_wake: assert property (p_wake) else $error("channel 2 woke off its pwm");
   c_pg: cover property ($rose(planes_power_good_o));
   c_save: cover property ($rose(power_save_active_o));
   c_off: cover property ($rose(core_plane_off_o));
endmodule : serial_vid_plane_control_assertions
bind serial_vid_plane_control serial_vid_plane_control_assertions #(
   .STEP_CYCLES(STEP_CYCLES)
) i_serial_vid_plane_control_assertions (.*);
`default_nettype wire

// ===== svi_host_model.sv
// host model sending set-vid frames on the serial voltage id bus
`timescale 1ns/10ps
`default_nettype none
module svi_host_model (
   input wire logic dev_oe_i,
   input wire logic dev_data_i,
   output logic clk_o,
   output logic data_o
);
   // ------------------
   // open-drain data with pull-up; link clock idles high
   // ------------------
   localparam realtime Q = 31.25;
   logic clk_q = 1'b1;
   logic drv_q = 1'b1;
   assign clk_o = clk_q;
   assign data_o = drv_q & (!dev_oe_i | dev_data_i);
   task automatic pins(input logic [1:0] v);
      clk_q <= v[1];
      drv_q <= v[0];
      #(4 * Q);
   endtask : pins
   task automatic bit_io(input logic b, output logic s);
      drv_q <= b;
      #Q clk_q <= 1'b1;
      #Q s = data_o;
      #Q clk_q <= 1'b0;
      #Q;
   endtask : bit_io
   task automatic send(input logic [15:0] f, output logic ack);
      logic s;
      ack = 1'b1;
      drv_q <= 1'b0;
      #(2 * Q) clk_q <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         bit_io(f[i], s);
         if (i % 8 == 0) begin
            bit_io(1'b1, s);
            ack &= !s;
         end
      end
      drv_q <= 1'b0;
      #Q clk_q <= 1'b1;
      #Q drv_q <= 1'b1;
      #(2 * Q);
   endtask : send
endmodule : svi_host_model
`default_nettype wire

// ===== serial_vid_plane_control_bench.sv
// self-checking bench for the serial vid plane control
`timescale 1ns/10ps
`default_nettype none
module serial_vid_plane_control_bench
   import svid_pkg::*;
;
   // ------------------
   // stimulus, partner and scenarios
   // ------------------
   logic ref_clk_i = 1'b0, arst_n_i = 1'b0, enable_i = 1'b0, fixed_vid_enable_i = 1'b0;
   logic platform_power_ok_i = 1'b0, planes_in_regulation_i = 1'b1;
   logic [3:0] phase_fitted_i = 4'hf, phase_pwm_i = 4'h0, phase_tristate_o;
   wire logic serial_vid_clock_i, serial_vid_data_i;
   logic serial_vid_data_o, serial_vid_data_oe_o, core_plane_off_o, planes_power_good_o;
   logic power_save_active_o, fixed_voltage_mode_o;
   level_t core_plane_ref_o, northbridge_plane_ref_o;
   int failures = 0, n_checks = 0, cycles = 0;
   serial_vid_plane_control #(.STEP_CYCLES(4)) i_serial_vid_plane_control (.*);
   svi_host_model i_svi_host_model (
      .dev_oe_i(serial_vid_data_oe_o),
      .dev_data_i(serial_vid_data_o),
      .clk_o(serial_vid_clock_i),
      .data_o(serial_vid_data_i)
   );
   always #5 ref_clk_i = ~ref_clk_i;
   // staggered two-cycle pwm pulses so each channel rises at its own time
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      phase_pwm_i <= (4'h1 << cycles[3:2]) & {4{!cycles[1]}};
      if (cycles == 40000) begin
         failures++;
         end_sim();
      end
   end
   function automatic level_t lvl(input int mv);
      return level_t'(mv * 2 / 25);
   endfunction : lvl
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic refs(input level_t c, input level_t n);
      for (int i = 0; i < 3000; i++) begin
         if (core_plane_ref_o === c && northbridge_plane_ref_o === n) break;
         @(negedge ref_clk_i);
      end
      chk(core_plane_ref_o, c);
      chk(northbridge_plane_ref_o, n);
   endtask : refs
   task automatic tri_st(input logic [3:0] t, input logic s);
      for (int i = 0; i < 3000; i++) begin
         if (phase_tristate_o === t && power_save_active_o === s) break;
         @(negedge ref_clk_i);
      end
      chk(phase_tristate_o, t);
      chk(power_save_active_o, s);
   endtask : tri_st
   task automatic cmd(input logic [7:0] a, input logic [7:0] d, input logic acked);
      logic ack;
      i_svi_host_model.send({a, d}, ack);
      chk(ack, acked);
   endtask : cmd
   task automatic t_fixed();
      int mv[4] = '{1400, 1200, 1000, 800};
      i_svi_host_model.pins(2'b00);
      @(posedge ref_clk_i);
      fixed_vid_enable_i <= 1'b1;
      enable_i <= 1'b1;
      refs(lvl(mv[0]), lvl(mv[0]));
      repeat (4) @(negedge ref_clk_i);
      chk(planes_power_good_o, 1'b1);
      chk(fixed_voltage_mode_o, 1'b1);
      for (int i = 1; i < 4; i++) begin
         i_svi_host_model.pins(2'(i));
         refs(lvl(mv[i]), lvl(mv[i]));
      end
      @(posedge ref_clk_i);
      enable_i <= 1'b0;
      refs(7'h00, 7'h00);
      chk(planes_power_good_o, 1'b0);
   endtask : t_fixed
   task automatic t_serial();
      @(posedge ref_clk_i);
      fixed_vid_enable_i <= 1'b0;
      i_svi_host_model.pins(2'b01);
      @(posedge ref_clk_i);
      enable_i <= 1'b1;
      refs(lvl(1000), lvl(1000));
      chk(fixed_voltage_mode_o, 1'b0);
      i_svi_host_model.pins(2'b11);
      @(posedge ref_clk_i);
      platform_power_ok_i <= planes_power_good_o;
      cmd(8'hcc, 8'h8c, 1'b1);
      refs(lvl(1400), lvl(1400));
      cmd(8'h4c, 8'h80, 1'b0);
      cmd(8'hcd, 8'h80, 1'b0);
      repeat (20) @(negedge ref_clk_i);
      chk(core_plane_ref_o, lvl(1400));
      cmd(8'hc4, 8'h80, 1'b1);
      refs(lvl(1400), lvl(1550));
      cmd(8'hc8, 8'hfb, 1'b1);
      refs(7'h01, lvl(1550));
      cmd(8'hc8, 8'hfc, 1'b1);
      refs(7'h00, lvl(1550));
      chk(core_plane_off_o, 1'b1);
      chk(planes_power_good_o, 1'b1);
   endtask : t_serial
   task automatic t_pok();
      @(posedge ref_clk_i);
      platform_power_ok_i <= 1'b0;
      refs(lvl(1000), lvl(1000));
      chk(core_plane_off_o, 1'b0);
      @(posedge ref_clk_i);
      platform_power_ok_i <= 1'b1;
      repeat (40) @(negedge ref_clk_i);
      chk(core_plane_ref_o, lvl(1000));
      cmd(8'hcc, 8'h8c, 1'b1);
      refs(lvl(1400), lvl(1400));
   endtask : t_pok
   task automatic t_save();
      cmd(8'hcc, 8'h0c, 1'b1);
      tri_st(4'he, 1'b1);
      cmd(8'hcc, 8'h10, 1'b1);
      tri_st(4'h8, 1'b0);
      chk(core_plane_ref_o, lvl(1400));
      tri_st(4'h0, 1'b0);
      refs(lvl(1350), lvl(1350));
      tri_st(4'he, 1'b1);
      cmd(8'hcc, 8'h90, 1'b1);
      tri_st(4'h0, 1'b0);
      @(posedge ref_clk_i);
      planes_in_regulation_i <= 1'b0;
      refs(7'h00, 7'h00);
      chk(planes_power_good_o, 1'b0);
   endtask : t_save
   task automatic end_sim();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim
   initial begin
      repeat (6) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      t_fixed();
      t_serial();
      t_pok();
      t_save();
      end_sim();
   end
endmodule : serial_vid_plane_control_bench
`default_nettype wire
